// ===== pkg/iodc_params.svh
`ifndef IODC_PARAMS_SVH
`define IODC_PARAMS_SVH
// Overview of operation
// - bit 31 of the ratio word set to one powers the divider down, zero powers it up.
// - bit 30 of the ratio word set to one disables the divider, zero enables it.
// - bit 29 of the ratio word holds the divider in reset while it is one.
// - the ratio sits in bits 24:0, resets to 0x64 and is never used below 14.
// - ratio bytes are staged and the whole ratio reaches the divider when the top byte is written.
// - writing bit 15 of the phase word from zero to one applies the offset unless pd, dis or rst is one, then the bit clears.
// - while bit 14 of the phase word is one, the offset is applied on each divider sync that finds no adjust in progress and pd, dis and rst all zero.
// - the offset is a nine-bit signed value in bits 8:0, positive delays, negative advances.
// - the applied offset magnitude never exceeds 255 oscillator periods.
// - the phase value is staged and becomes active when the byte holding bit 8 is written.

`define IODC_RATIO_OFS     32'h0000_0000
`define IODC_PHASE_OFS     32'h0000_0004
`define IODC_PD_BIT        31
`define IODC_DIS_BIT       30
`define IODC_RST_BIT       29
`define IODC_RATIO_MSB     24
`define IODC_RATIO_LANE    3
`define IODC_RATIO_RST     25'h000_0064
`define IODC_RATIO_MIN     25'h000_000E
`define IODC_NOW_BIT       15
`define IODC_POST_BIT      14
`define IODC_PHASE_MSB     8
`define IODC_PHASE_LANE    1
`define IODC_PHASE_RST     9'h000
`define IODC_PHASE_NEG_LIM 9'h100
`define IODC_PHASE_NEG_MAX 9'h101
`endif

// ===== pkg/iodc_pkg.sv
package iodc_pkg;
    typedef enum logic [1:0] {
        IODC_IDLE  = 2'b00,
        IODC_ISSUE = 2'b01,
        IODC_WAIT  = 2'b11
    } iodc_adj_state_t;

    typedef struct packed {
        logic        pd;
        logic        dis;
        logic        rst;
        logic [24:0] ratio_stage;
        logic [24:0] ratio_act;
        logic        now;
        logic        after_sync;
        logic [8:0]  phase_stage;
        logic [8:0]  phase_act;
        logic [31:0] rdata;
    } iodc_top_state_t;

    typedef struct packed {
        iodc_adj_state_t st;
        logic [2:0]      sync_sh;
        logic [2:0]      done_sh;
        logic [8:0]      offset;
        logic            start;
        logic            done;
        logic            pend;
        logic            imm;
    } iodc_eng_state_t;
endpackage

// ===== pkg/iodc_phase_if.sv
`timescale 1ns/1ps
interface iodc_phase_if;
    logic       start_now;
    logic       after_sync;
    logic       hold;
    logic [8:0] phase;
    logic       sync_pin;
    logic       done_pin;
    logic       adj_start;
    logic [8:0] adj_offset;
    logic       adj_done;

    modport ctrl (
        output start_now,
        output after_sync,
        output hold,
        output phase,
        output sync_pin,
        output done_pin,
        input  adj_start,
        input  adj_offset,
        input  adj_done
    );
    modport engine (
        input  start_now,
        input  after_sync,
        input  hold,
        input  phase,
        input  sync_pin,
        input  done_pin,
        output adj_start,
        output adj_offset,
        output adj_done
    );
endinterface

// ===== hdl/iodc_phase_engine.sv
`timescale 1ns/1ps
`include "iodc_params.svh"
module iodc_phase_engine
    import iodc_pkg::*;
(
    input  wire logic   ref_clk,
    input  wire logic   reset_n,
    iodc_phase_if.engine pif
);
    iodc_eng_state_t st;
    iodc_eng_state_t next_st;
    logic            sync_ev;
    logic            done_ev;

    // -256 cannot be applied, saturate to -255
    function automatic logic [8:0] iodc_sat(input logic [8:0] v);
        return (v == `IODC_PHASE_NEG_LIM) ? `IODC_PHASE_NEG_MAX : v;
    endfunction

    // first flop feeds only the second; edge taken between second and third
    assign sync_ev = st.sync_sh[1] & ~st.sync_sh[2];
    assign done_ev = st.done_sh[1] & ~st.done_sh[2];

    always_comb begin
        next_st         = st;
        next_st.sync_sh = {st.sync_sh[1:0], pif.sync_pin};
        next_st.done_sh = {st.done_sh[1:0], pif.done_pin};
        next_st.start   = 1'b0;
        next_st.done    = 1'b0;
        if (pif.start_now) begin
            next_st.pend = 1'b1;
        end
        case (st.st)
            IODC_IDLE: begin
                if (pif.hold) begin
                    // a trigger under hold is dropped so the bit cannot stick
                    next_st.done = st.pend | pif.start_now;
                    next_st.pend = 1'b0;
                end else if (st.pend | pif.start_now) begin
                    next_st.offset = iodc_sat(pif.phase);
                    next_st.start  = 1'b1;
                    next_st.imm    = 1'b1;
                    next_st.pend   = 1'b0;
                    next_st.st     = IODC_ISSUE;
                end else if (pif.after_sync & sync_ev) begin
                    next_st.offset = iodc_sat(pif.phase);
                    next_st.start  = 1'b1;
                    next_st.imm    = 1'b0;
                    next_st.st     = IODC_ISSUE;
                end
            end
            IODC_ISSUE: begin
                next_st.st = IODC_WAIT;
            end
            IODC_WAIT: begin
                if (done_ev | pif.hold) begin
                    next_st.done = st.imm;
                    next_st.imm  = 1'b0;
                    next_st.st   = IODC_IDLE;
                end
            end
            default: begin
                next_st.st = IODC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pif.adj_start  = st.start;
    assign pif.adj_offset = st.offset;
    assign pif.adj_done   = st.done;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_now_taken;
        (st.st == IODC_IDLE) && !pif.hold && pif.start_now;
    endsequence
    sequence s_issue;
        pif.adj_start ##1 (!pif.adj_start && st.st == IODC_WAIT);
    endsequence

    now_issue_a: assert property (s_now_taken |=> s_issue)
        else $error("immediate phase trigger did not issue an adjust");
    sync_issue_a: assert property ((st.st == IODC_IDLE) && !pif.hold && !st.pend
            && !pif.start_now && pif.after_sync && sync_ev |=> pif.adj_start)
        else $error("sync with after-sync set did not issue an adjust");
    no_sync_a: assert property ((st.st == IODC_IDLE) && !pif.after_sync && !st.pend
            && !pif.start_now |=> !pif.adj_start)
        else $error("adjust issued without a trigger");
    mag_limit_a: assert property (pif.adj_start |-> pif.adj_offset != `IODC_PHASE_NEG_LIM)
        else $error("phase offset magnitude above 255");
    offset_copy_a: assert property ($rose(pif.adj_start) && $past(pif.phase) != `IODC_PHASE_NEG_LIM
            |-> pif.adj_offset == $past(pif.phase))
        else $error("applied offset differs from programmed phase");
endmodule

// ===== hdl/iodc_top.sv
`timescale 1ns/1ps
`include "iodc_params.svh"
module iodc_top
    import iodc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              div_sync_pin,
    input  wire logic              adj_done_pin,
    output logic                   divider_power_down,
    output logic                   divider_disable,
    output logic                   divider_reset,
    output logic      [24:0]       divider_ratio,
    output logic                   phase_adj_start,
    output logic      [8:0]        phase_adj_offset
);
    iodc_top_state_t st;
    iodc_top_state_t next_st;
    iodc_phase_if    pif ();

    logic        hit_ratio;
    logic        hit_phase;
    logic        wr_ratio;
    logic        wr_phase;
    logic        rd_setup;
    logic        set_now;
    logic [31:0] ratio_word;
    logic [15:0] phase_word;

    // below-minimum ratios would break the divider, so they never reach it
    function automatic logic [24:0] iodc_clamp(input logic [24:0] v);
        return (v < `IODC_RATIO_MIN) ? `IODC_RATIO_MIN : v;
    endfunction

    assign hit_ratio = (paddr == ADDR_W'(`IODC_RATIO_OFS));
    assign hit_phase = (paddr == ADDR_W'(`IODC_PHASE_OFS));
    assign wr_ratio  = psel & penable & pwrite & hit_ratio;
    assign wr_phase  = psel & penable & pwrite & hit_phase;
    assign rd_setup  = psel & ~penable & ~pwrite;

    // read data is prepared in the setup cycle, so no wait state is needed
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(hit_ratio | hit_phase);

    always_comb begin
        next_st    = st;
        ratio_word = {st.pd, st.dis, st.rst, 4'h0, st.ratio_stage};
        phase_word = {1'b0, st.after_sync, 5'h00, st.phase_stage};
        set_now    = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (wr_ratio && pstrb[i]) begin
                ratio_word[i*8 +: 8] = pwdata[i*8 +: 8];
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (wr_phase && pstrb[i]) begin
                phase_word[i*8 +: 8] = pwdata[i*8 +: 8];
            end
        end
        if (wr_ratio) begin
            next_st.pd          = ratio_word[`IODC_PD_BIT];
            next_st.dis         = ratio_word[`IODC_DIS_BIT];
            next_st.rst         = ratio_word[`IODC_RST_BIT];
            next_st.ratio_stage = ratio_word[`IODC_RATIO_MSB:0];
            if (pstrb[`IODC_RATIO_LANE]) begin
                next_st.ratio_act = iodc_clamp(ratio_word[`IODC_RATIO_MSB:0]);
            end
        end
        if (wr_phase) begin
            next_st.after_sync  = phase_word[`IODC_POST_BIT];
            next_st.phase_stage = phase_word[`IODC_PHASE_MSB:0];
            set_now             = phase_word[`IODC_NOW_BIT];
            if (pstrb[`IODC_PHASE_LANE]) begin
                next_st.phase_act = phase_word[`IODC_PHASE_MSB:0];
            end
        end
        // a fresh set in the completion cycle wins over the self-clear
        next_st.now = (st.now & ~pif.adj_done) | set_now;
        if (rd_setup) begin
            if (hit_ratio) begin
                next_st.rdata = {st.pd, st.dis, st.rst, 4'h0, st.ratio_stage};
            end else if (hit_phase) begin
                next_st.rdata = {16'h0000, st.now, st.after_sync, 5'h00,
                                 st.phase_stage};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st           <= '0;
            st.ratio_stage <= `IODC_RATIO_RST;
            st.ratio_act   <= `IODC_RATIO_RST;
            st.phase_stage <= `IODC_PHASE_RST;
            st.phase_act   <= `IODC_PHASE_RST;
        end else begin
            st <= next_st;
        end
    end

    // only a zero-to-one write starts an adjust; rewriting a set bit is a no-op
    assign pif.start_now  = set_now & ~st.now;
    assign pif.after_sync = st.after_sync;
    // pd, dis and rst also stop adjusts in flight, covering a careless sequence
    assign pif.hold       = st.pd | st.dis | st.rst;
    // a trigger written with a new phase must carry that phase, not the old one
    assign pif.phase      = next_st.phase_act;
    assign pif.sync_pin   = div_sync_pin;
    assign pif.done_pin   = adj_done_pin;

    iodc_phase_engine u_engine (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pif     (pif)
    );

    assign prdata             = st.rdata;
    assign divider_power_down = st.pd;
    assign divider_disable    = st.dis;
    assign divider_reset      = st.rst;
    assign divider_ratio      = st.ratio_act;
    assign phase_adj_start    = pif.adj_start;
    assign phase_adj_offset   = pif.adj_offset;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ratio_wr_top;
        wr_ratio && pstrb[`IODC_RATIO_LANE];
    endsequence
    sequence s_phase_wr_low;
        wr_phase && pstrb[0] && !pstrb[`IODC_PHASE_LANE];
    endsequence

    pd_follows_a: assert property (s_ratio_wr_top |=>
            divider_power_down == $past(pwdata[`IODC_PD_BIT]))
        else $error("power-down output does not follow bit 31");
    dis_follows_a: assert property (s_ratio_wr_top |=>
            divider_disable == $past(pwdata[`IODC_DIS_BIT]))
        else $error("disable output does not follow bit 30");
    rst_follows_a: assert property (s_ratio_wr_top |=>
            divider_reset == $past(pwdata[`IODC_RST_BIT]))
        else $error("reset output does not follow bit 29");
    ctrl_stable_a: assert property (!wr_ratio |=> $stable(divider_power_down)
            && $stable(divider_disable) && $stable(divider_reset))
        else $error("divider control changed without a write");
    ratio_floor_a: assert property (divider_ratio >= `IODC_RATIO_MIN)
        else $error("divider ratio below minimum");
    ratio_commit_a: assert property (s_ratio_wr_top and ((&pstrb) && pwdata[`IODC_RATIO_MSB:0]
            >= `IODC_RATIO_MIN) |=> divider_ratio == $past(pwdata[`IODC_RATIO_MSB:0]))
        else $error("ratio not applied on top byte write");
    ratio_staged_a: assert property (wr_ratio && !pstrb[`IODC_RATIO_LANE]
            |=> $stable(divider_ratio))
        else $error("ratio changed before top byte write");
    phase_staged_a: assert property (s_phase_wr_low |=> $stable(st.phase_act))
        else $error("phase changed before bit 8 byte write");
    phase_commit_a: assert property (wr_phase && pstrb[0] && pstrb[`IODC_PHASE_LANE]
            |=> st.phase_act == $past(pwdata[`IODC_PHASE_MSB:0]))
        else $error("phase not activated on bit 8 byte write");
    now_clear_a: assert property (st.now && pif.adj_done && !set_now |=> !st.now)
        else $error("immediate apply bit did not self-clear");
    now_set_wins_a: assert property (set_now |=> st.now)
        else $error("immediate apply set was lost");
    rsv_zero_a: assert property (psel && penable && !pwrite && hit_ratio
            |-> prdata[`IODC_RST_BIT-1:`IODC_RATIO_MSB+1] == 4'h0)
        else $error("reserved ratio bits read nonzero");
    rsv_phase_a: assert property (psel && penable && !pwrite && hit_phase
            |-> prdata[31:16] == 16'h0000 && prdata[13:9] == 5'h00)
        else $error("reserved phase bits read nonzero");
    hold_stop_a: assert property (pif.hold && pif.start_now |-> ##[1:2] !phase_adj_start)
        else $error("adjust started while divider held");
endmodule

// ===== test/iodc_top_test.sv
`timescale 1ns/1ps
`include "iodc_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module iodc_top_test
    import iodc_pkg::*;
;
    logic        ref_clk;
    logic        reset_n;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        div_sync_pin;
    logic        adj_done_pin;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         pd_o;
    wire         dis_o;
    wire         rst_o;
    wire  [24:0] ratio_o;
    wire         start_o;
    wire  [8:0]  off_o;
    int          bad_count;
    int          n_compared;
    int          n_starts;
    int          n0;
    int          i;
    logic [8:0]  last_off;
    logic [31:0] rd;
    logic [2:0]  c;
    logic [2:0]  prev;
    logic [24:0] r;
    logic [24:0] nr;
    logic [8:0]  pa;
    logic [8:0]  pb;
    logic [2:0]  seq [8] = '{3'd1, 3'd5, 3'd1, 3'd3, 3'd1, 3'd7, 3'd1, 3'd0};
    logic [8:0]  pc [8] = '{9'h100, 9'h0FF, 9'h001, 9'h1FF, 9'h000, 9'h0, 9'h0, 9'h0};

    iodc_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .div_sync_pin(div_sync_pin),
        .adj_done_pin(adj_done_pin), .divider_power_down(pd_o), .divider_disable(dis_o),
        .divider_reset(rst_o), .divider_ratio(ratio_o), .phase_adj_start(start_o),
        .phase_adj_offset(off_o));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // pulse width counted at the edge; a stuck start shows as extra counts
    always @(posedge ref_clk) begin
        if (start_o === 1'b1) begin
            n_starts++;
            last_off = off_o;
        end
    end

    function automatic logic [24:0] clamp(input logic [24:0] v);
        return (v < 25'h000_000E) ? 25'h000_000E : v;
    endfunction

    function automatic logic [8:0] exp_off(input logic [8:0] p);
        return (p === 9'h100) ? 9'h101 : p;
    endfunction

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        `CHK(pslverr, (a != 12'h000 && a != 12'h004))
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input bit sync);
        if (sync) div_sync_pin <= 1'b1;
        else adj_done_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        div_sync_pin <= 1'b0;
        adj_done_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic ph_now(input logic [8:0] p);
        n0 = n_starts;
        apb(12'h004, 1'b1, {16'h0, 2'b10, 5'h1F, p}, 4'b0011);
        repeat (3) @(posedge ref_clk);
        `CHK(n_starts, n0 + 1)
        `CHK(last_off, exp_off(p))
        apb(12'h004, 1'b0, 32'h0, 4'h0);
        `CHK(rd, {16'h0, 2'b10, 5'h0, p})
        pulse(1'b0);
        apb(12'h004, 1'b0, 32'h0, 4'h0);
        `CHK(rd[15], 1'b0)
    endtask

    task automatic sync_chk(input logic [8:0] p);
        n0 = n_starts;
        pulse(1'b1);
        `CHK(n_starts, n0 + 1)
        `CHK(last_off, exp_off(p))
        pulse(1'b0);
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, div_sync_pin, adj_done_pin} = 5'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        void'($urandom(45718));
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        apb(12'h000, 1'b0, 32'h0, 4'h0);
        `CHK(rd, 32'h0000_0064)
        apb(12'h004, 1'b0, 32'h0, 4'h0);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
        // ratio only moves while reset was already held, keeping small ratios safe
        prev = 3'd0;
        r = 25'h000_0064;
        for (i = 0; i < 8; i++) begin
            c = seq[i];
            if (c[0] && prev[0]) begin
                r = (i == 2) ? 25'h000_000E : (i == 4) ? 25'h000_000D :
                    (i == 5) ? 25'h1FF_FFFF : 25'($urandom_range(32'h1FF_FFFF, 32'hE));
            end
            apb(12'h000, 1'b1, {c, 4'hF, r}, 4'hF);
            @(negedge ref_clk);
            `CHK({pd_o, dis_o, rst_o}, c)
            `CHK(ratio_o, clamp(r))
            apb(12'h000, 1'b0, 32'h0, 4'h0);
            `CHK(rd, {c, 4'h0, r})
            prev = c;
        end
        $display("test control done");
        nr = {1'b1, 24'($urandom)};
        apb(12'h000, 1'b1, {3'd1, 4'h0, r}, 4'b1000);
        apb(12'h000, 1'b1, {3'd1, 4'h0, nr}, 4'b0111);
        @(negedge ref_clk);
        `CHK(ratio_o, clamp(r))
        apb(12'h000, 1'b0, 32'h0, 4'h0);
        `CHK(rd, {3'd1, 4'h0, r[24], nr[23:0]})
        apb(12'h000, 1'b1, {3'd1, 4'hF, nr}, 4'b1000);
        @(negedge ref_clk);
        `CHK(ratio_o, nr)
        apb(12'h000, 1'b1, {3'd0, 4'h0, nr}, 4'b1000);
        $display("test staging done");
        for (i = 0; i < 8; i++) begin
            ph_now((i < 5) ? pc[i] : 9'($urandom)); // ratio far above twice 255
        end
        $display("test phase now done");
        pa = 9'($urandom);
        pb = ~pa;
        n0 = n_starts;
        apb(12'h004, 1'b1, {16'h0, 2'b01, 5'h0, pa}, 4'b0011);
        repeat (4) @(posedge ref_clk);
        `CHK(n_starts, n0)
        sync_chk(pa);
        apb(12'h004, 1'b1, {16'h0, 2'b01, 5'h0, pb}, 4'b0001);
        apb(12'h004, 1'b0, 32'h0, 4'h0);
        `CHK(rd, {16'h0, 2'b01, 5'h0, pa[8], pb[7:0]})
        sync_chk(pa);
        apb(12'h004, 1'b1, {16'h0, 2'b01, 5'h0, pb[8], 8'h00}, 4'b0010);
        sync_chk(pb);
        apb(12'h004, 1'b1, 32'h0, 4'b0011);
        $display("test phase sync done");
        // refused on purpose: trigger while the divider is held in reset
        apb(12'h000, 1'b1, {3'd1, 4'h0, nr}, 4'b1000);
        n0 = n_starts;
        apb(12'h004, 1'b1, {16'h0, 2'b10, 5'h0, 9'h005}, 4'b0011);
        repeat (4) @(posedge ref_clk);
        `CHK(n_starts, n0)
        apb(12'h008, 1'b0, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        apb(12'h010, 1'b1, 32'hFFFF_FFFF, 4'hF);
        apb(12'h000, 1'b0, 32'h0, 4'h0);
        `CHK(rd, {3'd1, 4'h0, nr})
        $display("test refusal done");
        test_done();
    end
endmodule
